//--- src/switch_mgmt_defines.vh
// constants for the switch management register access block
// assumes a byte-addressed management access port with 16-bit addresses
`ifndef SWITCH_MGMT_DEFINES_VH
`define SWITCH_MGMT_DEFINES_VH

// --------------------------------------------------------------
// port window (address bits 15:12 select the port)
// --------------------------------------------------------------
`define PHY_PORT_FIRST 4'h1
`define PHY_PORT_LAST 4'h5
`define PHY_PORT_COUNT 5
`define PHY_WIN_BASE 12'h100
`define PHY_WIN_LAST 12'h13f
`define PHY_WIN_UPPER 12'h120
`define PHY_REGS_PER_PORT 32

// --------------------------------------------------------------
// phy register numbers and fields
// --------------------------------------------------------------
`define PHY_REG_BASIC_CTRL 5'h00
`define PHY_REG_MMD_SETUP 5'h0d
`define PHY_REG_MMD_DATA 5'h0e
`define BASIC_CTRL_RESET 16'h1140
`define BASIC_CTRL_AN_EN_BIT 12
`define BASIC_CTRL_PWR_DOWN_BIT 11
`define MMD_FUNC_HI 15
`define MMD_FUNC_LO 14
`define MMD_FUNC_ADDR 2'h0

// --------------------------------------------------------------
// mmd registers held by this block
// --------------------------------------------------------------
`define MMD_DEV_EEE 5'h07
`define MMD_REG_EEE_ADV 16'h003c
`define EEE_ADV_RESET 16'h0006
`define EEE_ADV_HI 2
`define EEE_ADV_LO 1
`define MMD_DEV_TXAMP 5'h1c
`define MMD_REG_TXAMP 16'h0004
`define TXAMP_RESET 16'h0000

// --------------------------------------------------------------
// global registers
// --------------------------------------------------------------
`define PORT6_XMII_CTRL_ADDR 16'h6301
`define PORT6_XMII_CTRL_RESET 8'h00
`define XMII_RX_DELAY_BIT 4
`define SGMII_IND_ADDR_ADDR 16'h7200
`define SGMII_IND_DATA_ADDR 16'h7206
`define SGMII_AN_ADV_REG 32'h001f0004
`define SGMII_AN_ADV_RESET 16'h0000
`define SGMII_CODE_DEFAULT 16'h0000
`define SGMII_CODE_FIXED 16'h0001

// access sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`endif

//--- src/switch_phy_mgmt_register_access.v
// management register bank: phy windows, mmd path, port 6 and sgmii regs
// assumes one synchronous access port fed by any management path
//
// Behaviour
// - each of ports 1 to 5 has 16-bit phy registers at 0xN100 to 0xN13F
// - lower window accepts 8- and 16-bit writes touching only addressed bytes
// - upper window writes act as 32-bit, zeroing the unaddressed bytes
// - reads in the upper window behave normally
// - port 6 control bit 4 adds rgmii receive ingress delay
// - eee enabled by default, active only with autoneg and both advertising
// - clearing mmd 7 register 0x3c bits 2:1 withdraws eee advertisement
// - basic control bit 11 powers down only that phy while set
// - sgmii code word defaults to 0x0000 instead of 0x0001
// - indirect sgmii write is address at 0x7200 then data at 0x7206
// - every management path reaches the registers with identical effect
`timescale 1ns/10ps
`include "switch_mgmt_defines.vh"

module switch_phy_mgmt_register_access (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// management access port
	input wire req_i,
	input wire write_i,
	input wire [1:0] path_i,
	input wire [15:0] addr_i,
	input wire [1:0] size_i,
	input wire [31:0] wdata_i,
	output reg ack_o,
	output reg [31:0] rdata_o,
	// phy side
	input wire [4:0] partner_eee_i,
	output reg [4:0] phy_power_down_o,
	output reg [4:0] phy_an_enable_o,
	output reg [4:0] eee_active_o,
	// port 6 and port 7
	output reg rgmii_rx_delay_o,
	output reg [15:0] sgmii_code_word_o
);

	// ----------------------------------------------------------
	// reset release
	// ----------------------------------------------------------
	reg rst_meta_b;
	reg rst_b;

	// two-stage release of the asynchronous reset
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_b <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_b <= rst_meta_b;
		end
	end

	// ----------------------------------------------------------
	// address decode
	// ----------------------------------------------------------
	reg [15:0] phy_reg [0:`PHY_PORT_COUNT*`PHY_REGS_PER_PORT-1];
	reg [15:0] mmd_addr [0:`PHY_PORT_COUNT-1];
	reg [15:0] eee_adv [0:`PHY_PORT_COUNT-1];
	reg [15:0] tx_amp [0:`PHY_PORT_COUNT-1];
	reg [7:0] port6_xmii_control;
	reg [31:0] sgmii_indirect_address;
	reg [15:0] sgmii_an_adv;
	reg sgmii_fixed;

	wire [3:0] port_num = addr_i[15:12];
	wire [11:0] win_off = addr_i[11:0];
	wire [2:0] port_idx = port_num[2:0] - 3'h1;
	// path_i is not decoded: every path lands here the same way
	wire phy_hit = (port_num >= `PHY_PORT_FIRST) &&
		(port_num <= `PHY_PORT_LAST) &&
		(win_off >= `PHY_WIN_BASE) && (win_off <= `PHY_WIN_LAST);
	wire upper = win_off >= `PHY_WIN_UPPER;
	// aligned pair of 16-bit registers, byte bits 1:0 dropped
	wire [7:0] hi_idx = {port_idx, addr_i[5:2], 1'b0};
	wire [7:0] lo_idx = {port_idx, addr_i[5:2], 1'b1};
	wire [4:0] hi_num = {addr_i[5:2], 1'b0};
	wire [4:0] lo_num = {addr_i[5:2], 1'b1};
	wire [1:0] mmd_func = phy_reg[{port_idx, `PHY_REG_MMD_SETUP}]
		[`MMD_FUNC_HI:`MMD_FUNC_LO];
	wire [4:0] mmd_dev = phy_reg[{port_idx, `PHY_REG_MMD_SETUP}][4:0];

	// ----------------------------------------------------------
	// lane steering for the addressed pair (big-endian bytes)
	// ----------------------------------------------------------
	reg [31:0] lane_data;
	reg [3:0] lane_en;

	// place the write data onto the 32-bit pair and mark its bytes
	always @* begin
		case (size_i)
		`SIZE_WORD: begin
			lane_data = wdata_i;
			lane_en = 4'hf;
		end
		`SIZE_HALF: begin
			lane_data = addr_i[1] ? {16'h0000, wdata_i[15:0]} :
				{wdata_i[15:0], 16'h0000};
			lane_en = addr_i[1] ? 4'h3 : 4'hc;
		end
		default: begin
			lane_data = {4{wdata_i[7:0]}};
			lane_en = 4'h8 >> addr_i[1:0];
		end
		endcase
	end

	// ----------------------------------------------------------
	// mmd indirect read value
	// ----------------------------------------------------------
	reg [15:0] mmd_rd;

	// value seen through the mmd data register
	always @* begin
		mmd_rd = 16'h0000;
		if (mmd_func == `MMD_FUNC_ADDR) begin
			mmd_rd = mmd_addr[port_idx];
		end else if (mmd_dev == `MMD_DEV_EEE &&
			mmd_addr[port_idx] == `MMD_REG_EEE_ADV) begin
			mmd_rd = eee_adv[port_idx];
		end else if (mmd_dev == `MMD_DEV_TXAMP &&
			mmd_addr[port_idx] == `MMD_REG_TXAMP) begin
			mmd_rd = tx_amp[port_idx];
		end
	end

	// ----------------------------------------------------------
	// read mux
	// ----------------------------------------------------------
	reg [15:0] rd_hi;
	reg [15:0] rd_lo;
	reg [31:0] rd_pair;
	reg [31:0] next_rdata;

	// phy window reads never widen; they return the addressed bytes only
	always @* begin
		rd_hi = (hi_num == `PHY_REG_MMD_DATA) ? mmd_rd : phy_reg[hi_idx];
		rd_lo = (lo_num == `PHY_REG_MMD_DATA) ? mmd_rd : phy_reg[lo_idx];
		rd_pair = {rd_hi, rd_lo} >> {~addr_i[1:0], 3'b000}; // byte to [7:0]
		next_rdata = 32'h00000000;
		if (phy_hit) begin
			case (size_i)
			`SIZE_WORD: next_rdata = {rd_hi, rd_lo};
			`SIZE_HALF: next_rdata = {16'h0000, addr_i[1] ? rd_lo : rd_hi};
			default: next_rdata = {24'h000000, rd_pair[7:0]};
			endcase
		end else if (addr_i == `PORT6_XMII_CTRL_ADDR) begin
			next_rdata = {24'h000000, port6_xmii_control};
		end else if (addr_i == `SGMII_IND_ADDR_ADDR) begin
			next_rdata = sgmii_indirect_address;
		end else if (addr_i == `SGMII_IND_DATA_ADDR) begin
			next_rdata = {16'h0000,
				(sgmii_indirect_address == `SGMII_AN_ADV_REG) ?
				sgmii_an_adv : 16'h0000};
		end
	end

	// ----------------------------------------------------------
	// write side of the phy window
	// ----------------------------------------------------------
	// upper window: every byte of the pair is written, unaddressed ones zero
	wire [3:0] wr_en = upper ? 4'hf : lane_en;
	wire [31:0] wr_data = upper ? (lane_data & {{8{lane_en[3]}},
		{8{lane_en[2]}}, {8{lane_en[1]}}, {8{lane_en[0]}}}) : lane_data;
	wire [15:0] new_hi = {wr_en[3] ? wr_data[31:24] : phy_reg[hi_idx][15:8],
		wr_en[2] ? wr_data[23:16] : phy_reg[hi_idx][7:0]};
	wire [15:0] new_lo = {wr_en[1] ? wr_data[15:8] : phy_reg[lo_idx][15:8],
		wr_en[0] ? wr_data[7:0] : phy_reg[lo_idx][7:0]};
	wire phy_wr = req_i && write_i && phy_hit;
	wire mmd_wr_hi = phy_wr && (wr_en[3:2] != 2'b00) &&
		(hi_num == `PHY_REG_MMD_DATA);
	wire mmd_wr_lo = phy_wr && (wr_en[1:0] != 2'b00) &&
		(lo_num == `PHY_REG_MMD_DATA);
	wire [15:0] mmd_wval = mmd_wr_hi ? new_hi : new_lo;

	integer i;

	// register file updates
	always @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < `PHY_PORT_COUNT*`PHY_REGS_PER_PORT; i = i + 1) begin
				phy_reg[i] <= ((i % `PHY_REGS_PER_PORT) == 0) ?
					`BASIC_CTRL_RESET : 16'h0000;
			end
			for (i = 0; i < `PHY_PORT_COUNT; i = i + 1) begin
				mmd_addr[i] <= 16'h0000;
				eee_adv[i] <= `EEE_ADV_RESET;
				tx_amp[i] <= `TXAMP_RESET;
			end
			port6_xmii_control <= `PORT6_XMII_CTRL_RESET;
			sgmii_indirect_address <= 32'h00000000;
			sgmii_an_adv <= `SGMII_AN_ADV_RESET;
			sgmii_fixed <= 1'b0;
		end else if (req_i && write_i) begin
			if (phy_hit) begin
				if (wr_en[3:2] != 2'b00) begin
					phy_reg[hi_idx] <= new_hi;
				end
				if (wr_en[1:0] != 2'b00) begin
					phy_reg[lo_idx] <= new_lo;
				end
				// data register goes to the mmd address or the target
				if (mmd_wr_hi || mmd_wr_lo) begin
					if (mmd_func == `MMD_FUNC_ADDR) begin
						mmd_addr[port_idx] <= mmd_wval;
					end else if (mmd_dev == `MMD_DEV_EEE &&
						mmd_addr[port_idx] == `MMD_REG_EEE_ADV) begin
						eee_adv[port_idx] <= mmd_wval;
					end else if (mmd_dev == `MMD_DEV_TXAMP &&
						mmd_addr[port_idx] == `MMD_REG_TXAMP) begin
						tx_amp[port_idx] <= mmd_wval;
					end
				end
			end else if (addr_i == `PORT6_XMII_CTRL_ADDR) begin
				port6_xmii_control <= wdata_i[7:0];
			end else if (addr_i == `SGMII_IND_ADDR_ADDR) begin
				sgmii_indirect_address <= wdata_i;
			end else if (addr_i == `SGMII_IND_DATA_ADDR) begin
				// second step lands on the register named in step one only if that is 0x001f0004
				if (sgmii_indirect_address == `SGMII_AN_ADV_REG) begin
					sgmii_an_adv <= wdata_i[15:0];
					sgmii_fixed <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------
	integer p;

	// answer and status outputs, all from flip-flops
	always @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ack_o <= 1'b0;
			rdata_o <= 32'h00000000;
			phy_power_down_o <= 5'h00;
			phy_an_enable_o <= 5'h00;
			eee_active_o <= 5'h00;
			rgmii_rx_delay_o <= 1'b0;
			sgmii_code_word_o <= `SGMII_CODE_DEFAULT;
		end else begin
			ack_o <= req_i;
			rdata_o <= (req_i && !write_i) ? next_rdata : 32'h00000000;
			for (p = 0; p < `PHY_PORT_COUNT; p = p + 1) begin
				phy_power_down_o[p] <= phy_reg[p*`PHY_REGS_PER_PORT]
					[`BASIC_CTRL_PWR_DOWN_BIT];
				phy_an_enable_o[p] <= phy_reg[p*`PHY_REGS_PER_PORT]
					[`BASIC_CTRL_AN_EN_BIT];
				eee_active_o[p] <= phy_reg[p*`PHY_REGS_PER_PORT]
					[`BASIC_CTRL_AN_EN_BIT] && partner_eee_i[p] &&
					(eee_adv[p][`EEE_ADV_HI:`EEE_ADV_LO] != 2'b00);
			end
			rgmii_rx_delay_o <= port6_xmii_control[`XMII_RX_DELAY_BIT];
			sgmii_code_word_o <= sgmii_fixed ? `SGMII_CODE_FIXED :
				`SGMII_CODE_DEFAULT;
		end
	end

endmodule

//--- verif/switch_phy_mgmt_register_access_chk.sv
// assertions on the management register bank ports
// assumes status outputs lag their register by one cycle
`timescale 1ns/10ps
module switch_phy_mgmt_register_access_chk (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// access port
	input wire req_i,
	input wire write_i,
	input wire [15:0] addr_i,
	input wire [1:0] size_i,
	input wire [31:0] wdata_i,
	input wire ack_o,
	// status
	input wire [4:0] partner_eee_i,
	input wire [4:0] phy_power_down_o,
	input wire [4:0] phy_an_enable_o,
	input wire [4:0] eee_active_o,
	input wire rgmii_rx_delay_o,
	input wire [15:0] sgmii_code_word_o
);
	// ------------------------------
	// write sequences and checks
	// ------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence ctl_wr;
		req_i && write_i && size_i == 2'h1 && addr_i[11:0] == 12'h100
			&& addr_i[15:12] >= 4'h1 && addr_i[15:12] <= 4'h5;
	endsequence
	sequence ind_addr;
		req_i && write_i && addr_i == 16'h7200 && wdata_i == 32'h001f0004;
	endsequence
	sequence ind_data;
		req_i && write_i && addr_i == 16'h7206;
	endsequence
	a_ack_after_req: assert property (req_i |=> ack_o)
		else $error("request not acked");
	a_ack_only_req: assert property (!req_i |=> !ack_o)
		else $error("ack without request");
	a_ctl_bits_out: assert property (ctl_wr |-> ##2
		{phy_an_enable_o[$past(addr_i[15:12], 2) - 4'h1],
		phy_power_down_o[$past(addr_i[15:12], 2) - 4'h1]}
		== $past(wdata_i[12:11], 2)) else $error("control bits lost");
	a_rx_delay_bit: assert property (req_i && write_i
		&& addr_i == 16'h6301 |-> ##2 rgmii_rx_delay_o == $past(wdata_i[4], 2))
		else $error("rx delay bit wrong");
	a_eee_partner: assert property (
		(eee_active_o & ~$past(partner_eee_i)) == 5'h00)
		else $error("eee active without partner");
	a_eee_autoneg: assert property (
		(eee_active_o & ~(phy_an_enable_o | $past(phy_an_enable_o))) == 5'h00)
		else $error("eee active without autoneg");
	a_code_fix: assert property (ind_addr ##[1:4] ind_data |-> ##2
		sgmii_code_word_o == 16'h0001) else $error("code word not fixed");
	a_code_cause: assert property ($rose(sgmii_code_word_o[0]) |->
		$past(req_i && write_i && addr_i == 16'h7206, 2))
		else $error("code word changed alone");
endmodule

bind switch_phy_mgmt_register_access switch_phy_mgmt_register_access_chk chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .write_i(write_i),
	.addr_i(addr_i), .size_i(size_i), .wdata_i(wdata_i), .ack_o(ack_o),
	.partner_eee_i(partner_eee_i), .phy_power_down_o(phy_power_down_o),
	.phy_an_enable_o(phy_an_enable_o), .eee_active_o(eee_active_o),
	.rgmii_rx_delay_o(rgmii_rx_delay_o),
	.sgmii_code_word_o(sgmii_code_word_o));

//--- verif/mgmt_host.sv
// host model: one request at a time on the management access port
// assumes the block acks within three cycles of taking a request
`timescale 1ns/10ps
module mgmt_host (
	// clock and answer
	input wire clk_i,
	input wire ack_i,
	input wire [31:0] rdata_i,
	// request
	output logic req_o,
	output logic write_o,
	output logic [1:0] path_o,
	output logic [15:0] addr_o,
	output logic [1:0] size_o,
	output logic [31:0] wdata_o
);
	// idle port at time zero
	initial {req_o, write_o, path_o, addr_o, size_o, wdata_o} = 54'h0;
	// one request pulse, then a bounded wait for the ack
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [1:0] s, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		ok = 1'b0;
		q = 32'h0;
		@(negedge clk_i);
		{req_o, write_o, addr_o, size_o, wdata_o} = {1'b1, w, a, s, d};
		@(negedge clk_i);
		req_o = 1'b0;
		for (int k = 0; k < 3 && !ok; k++) begin
			ok = (ack_i === 1'b1);
			q = rdata_i;
			if (!ok)
				@(negedge clk_i);
		end
		path_o = path_o + 2'h1;
		wdata_o = ~d; // released data does not hold its value
	endtask
endmodule

//--- verif/test_switch_phy_mgmt_register_access.sv
// self-checking bench for the management register bank
// assumes the host model in mgmt_host drives the access port
`timescale 1ns/10ps
`include "switch_mgmt_defines.vh"
module test_switch_phy_mgmt_register_access;
	localparam logic [1:0] sb = `SIZE_BYTE, sh = `SIZE_HALF, sw = `SIZE_WORD;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [4:0] partner_eee_i = 5'h1f;
	wire req_i, write_i, ack_o, rgmii_rx_delay_o;
	wire [1:0] path_i, size_i;
	wire [15:0] addr_i, sgmii_code_word_o;
	wire [31:0] wdata_i, rdata_o;
	wire [4:0] phy_power_down_o, phy_an_enable_o, eee_active_o;
	int n_mismatch = 0;
	int checked = 0;
	// ------------------------------
	// clock, block and host
	// ------------------------------
	initial forever #4 clk_i = ~clk_i;
	switch_phy_mgmt_register_access uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.req_i(req_i), .write_i(write_i), .path_i(path_i), .addr_i(addr_i),
		.size_i(size_i), .wdata_i(wdata_i), .ack_o(ack_o), .rdata_o(rdata_o),
		.partner_eee_i(partner_eee_i), .phy_power_down_o(phy_power_down_o),
		.phy_an_enable_o(phy_an_enable_o), .eee_active_o(eee_active_o),
		.rgmii_rx_delay_o(rgmii_rx_delay_o),
		.sgmii_code_word_o(sgmii_code_word_o));
	mgmt_host host (.clk_i(clk_i), .ack_i(ack_o), .rdata_i(rdata_o),
		.req_o(req_i), .write_o(write_i), .path_o(path_i), .addr_o(addr_i),
		.size_o(size_i), .wdata_o(wdata_i));
	// verdict and end of run
	task automatic end_sim;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// one access; for reads d is the expected value
	task automatic acc(input logic [15:0] a, input logic [1:0] s,
		input logic [31:0] d, input logic w = 1'b1);
		logic [31:0] q;
		logic ok;
		host.acc(w, a, s, w ? d : 32'h0, q, ok);
		if (!ok) begin
			n_mismatch++;
			end_sim();
		end else if (!w) begin
			chk(q, d);
		end
	endtask
	// status outputs once a write has settled
	task automatic outs(input logic [4:0] pd, input logic [4:0] an,
		input logic [4:0] ee);
		repeat (3) @(negedge clk_i);
		chk({17'h0, phy_power_down_o, phy_an_enable_o, eee_active_o},
			{17'h0, pd, an, ee});
	endtask
	// point the mmd data register at device dev register r
	task automatic mmd_sel(input logic [4:0] dev, input logic [15:0] r);
		acc(16'h111a, sh, {27'h0, dev});
		acc(16'h111c, sh, {16'h0, r});
		acc(16'h111a, sh, {27'h0, dev} | 32'h4000);
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk_i);
		rst_b_i = 1'b1;
		outs(5'h00, 5'h1f, 5'h1f);
		chk({16'h0, sgmii_code_word_o}, 32'h0);
		acc(16'h1100, sh, 32'h1140, 1'b0);
		partner_eee_i = 5'h0a;
		outs(5'h00, 5'h1f, 5'h0a);
		partner_eee_i = 5'h1f;
		$display("test done: defaults");
		acc(16'h1108, sh, 32'h1234);
		acc(16'h1109, sb, 32'h56);
		acc(16'h1108, sh, 32'h1256, 1'b0);
		acc(16'h1120, sw, 32'h11112222);
		acc(16'h1122, sh, 32'h3333);
		acc(16'h1120, sw, 32'h3333, 1'b0);
		acc(16'h1120, sw, 32'h00004444);
		acc(16'h1122, sh, 32'h4444, 1'b0);
		acc(16'h1120, sh, 32'h0, 1'b0);
		acc(16'h113f, sb, 32'h77);
		acc(16'h113c, sh, 32'h0, 1'b0);
		acc(16'h113e, sh, 32'h77, 1'b0);
		acc(16'h6140, sh, 32'h0, 1'b0);
		$display("test done: register window");
		acc(16'h1100, sh, 32'h2100);
		outs(5'h00, 5'h1e, 5'h1e);
		mmd_sel(5'h1c, 16'h0004);
		acc(16'h111c, sh, 32'h00d0);
		acc(16'h111c, sh, 32'h00d0, 1'b0);
		mmd_sel(5'h07, 16'h003c);
		acc(16'h111c, sh, 32'h0006, 1'b0);
		acc(16'h111c, sh, 32'h0);
		acc(16'h1100, sh, 32'h1340);
		outs(5'h00, 5'h1f, 5'h1e);
		acc(16'h3100, sh, 32'h0800);
		outs(5'h04, 5'h1b, 5'h1a);
		acc(16'h3100, sh, 32'h1140);
		outs(5'h00, 5'h1f, 5'h1e);
		$display("test done: phy control");
		acc(16'h6301, sb, 32'h10);
		acc(16'h7200, sw, 32'h001f0004);
		acc(16'h7206, sh, 32'h01a0);
		repeat (3) @(negedge clk_i);
		chk({15'h0, rgmii_rx_delay_o, sgmii_code_word_o}, 32'h10001);
		acc(16'h7206, sh, 32'h01a0, 1'b0);
		$display("test done: port 6 and 7");
		// reset again in mid-run: code word and delay bit fall back
		rst_b_i = 1'b0;
		repeat (4) @(negedge clk_i);
		rst_b_i = 1'b1;
		outs(5'h00, 5'h1f, 5'h1f);
		chk({15'h0, rgmii_rx_delay_o, sgmii_code_word_o}, 32'h0);
		acc(16'h1100, sh, 32'h1140, 1'b0);
		acc(16'h7200, sw, 32'h001f0004);
		acc(16'h7206, sh, 32'h01a0);
		repeat (3) @(negedge clk_i);
		chk({16'h0, sgmii_code_word_o}, 32'h1);
		$display("test done: reset again");
		end_sim();
	end
endmodule
